// ### rtl/fepcs_defines.vh
// Constants for the flash erase and programming command sequencer
`ifndef FEPCS_DEFINES_VH
`define FEPCS_DEFINES_VH

// Status codes
`define FEPCS_ST_ACK 8'h06
`define FEPCS_ST_PARAM 8'h05
`define FEPCS_ST_CSUM 8'h07
`define FEPCS_ST_PROTECT 8'h10
`define FEPCS_ST_NACK 8'h15
`define FEPCS_ST_FAIL 8'h1a
`define FEPCS_ST_VERIFY 8'h1b
`define FEPCS_ST_WRITE 8'h1c

// Command codes as decoded from a parsed command frame
`define FEPCS_CMD_STATUS 2'h0
`define FEPCS_CMD_ERASE 2'h1
`define FEPCS_CMD_PROG 2'h2
`define FEPCS_CMD_OTHER 2'h3

// Block geometry: 1 KB units, low address bits
`define FEPCS_BLK_BITS 10
`define FEPCS_BLK_LOW 10'h000
`define FEPCS_BLK_HIGH 10'h3ff

// Frame payload limit and FIFO shape
`define FEPCS_FRAME_MAX 256
`define FEPCS_FIFO_DEPTH 16
`define FEPCS_FIFO_AW 4

// Internal verify time per block, in ns, and derived cycle count
`define FEPCS_CLK_NS 50
`define FEPCS_VERIFY_NS 1000
`define FEPCS_VERIFY_CYC ((`FEPCS_VERIFY_NS + `FEPCS_CLK_NS - 1) / `FEPCS_CLK_NS)

`endif

// ### rtl/fepcs_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module fepcs_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire clock,
	input wire nrst,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output reg [WIDTH-1:0] out_data
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wp_r;
reg [AW-1:0] rp_r;
reg [AW:0] cnt_r;
reg oval_r;
wire push;
wire pop;
wire load;

localparam [AW:0] FULL = DEPTH;

assign in_ready = (cnt_r != FULL);
assign push = in_valid & in_ready;
assign out_valid = oval_r;
// Fetch into output register when empty or consumed
assign load = (cnt_r != {(AW+1){1'b0}}) & (~oval_r | out_ready);
assign pop = oval_r & out_ready;

// Storage write
always @(posedge clock) begin
	if (push)
		mem[wp_r] <= in_data;
end

// Pointers, count and registered read data
always @(posedge clock or negedge nrst) begin
	if (!nrst) begin
		wp_r <= {AW{1'b0}};
		rp_r <= {AW{1'b0}};
		cnt_r <= {(AW+1){1'b0}};
		oval_r <= 1'b0;
		out_data <= {WIDTH{1'b0}};
	end else begin
		if (push)
			wp_r <= wp_r + 1'b1;
		if (load) begin
			out_data <= mem[rp_r];
			rp_r <= rp_r + 1'b1;
			oval_r <= 1'b1;
		end else if (pop) begin
			oval_r <= 1'b0;
		end
		if (push & ~load)
			cnt_r <= cnt_r + 1'b1;
		else if (~push & load)
			cnt_r <= cnt_r - 1'b1;
	end
end

endmodule

// ### rtl/fepcs_seq.v
// Flash block erase and programming command sequencer
`timescale 1ns/100ps
`include "fepcs_defines.vh"

// Summary of operation
// - Successful block erase answers with acknowledge as first status byte.
// - Erase range not on block boundaries answers parameter error.
// - Command frame with bad checksum answers checksum error.
// - Erase forbidden by security or boot protection answers protect error.
// - Malformed command frame answers negative acknowledge.
// - Non-status command while busy answers negative acknowledge.
// - Erase failure answers erase error as first status byte.
// - Each data frame gets two status bytes; write error ends programming.
// - Final status after programming is acknowledge or internal verify error.
// - Program range not 1 KB aligned answers parameter error.
// - Program forbidden by security or boot protection answers protect error.
// - Bad checksum on command or data frame answers checksum error.
// - Write failure answers acknowledge first and write failure code as second status byte.
module fepcs_seq #(
	parameter AW = 20,
	parameter VERIFY_CYC = `FEPCS_VERIFY_CYC
) (
	// Clock and reset
	input wire clock,
	input wire nrst,
	// Parsed command frame
	input wire cmd_valid,
	input wire [1:0] cmd_code,
	input wire cmd_csum_ok,
	input wire cmd_form_ok,
	input wire [AW-1:0] cmd_start_addr,
	input wire [AW-1:0] cmd_end_addr,
	// Parsed data frame, one byte per beat
	input wire data_valid,
	output wire data_ready,
	input wire [7:0] data_byte,
	input wire data_frame_end,
	input wire data_frame_last,
	input wire data_csum_ok,
	// Security settings, level pins
	input wire sec_write_dis,
	input wire sec_blk_erase_dis,
	input wire sec_chip_erase_dis,
	input wire sec_boot_dis,
	input wire [AW-1:0] boot_end_addr,
	// Flash array port
	output reg fl_erase_r,
	output reg fl_write_r,
	output reg [AW-1:0] fl_addr_r,
	output reg [7:0] fl_wdata_r,
	input wire fl_done,
	input wire fl_fail,
	input wire fl_verify_ok,
	// Status frame request
	output reg stat_valid_r,
	output reg stat_two_r,
	output reg [7:0] first_status_byte,
	output reg [7:0] second_status_byte,
	output reg busy_r
);

// States
localparam S_IDLE = 3'h0;
localparam S_ERASE = 3'h1;
localparam S_RECV = 3'h2;
localparam S_WRITE = 3'h3;
localparam S_VERIFY = 3'h4;
localparam S_DRAIN = 3'h5;

reg [2:0] state_r;
reg [2:0] state_nxt;
reg [AW-1:0] cur_r;
reg [AW-1:0] end_r;
reg [AW-`FEPCS_BLK_BITS:0] blocks_r;
reg [31:0] vcnt_r;
reg frame_bad_r;
reg frame_last_r;
reg wr_fail_r;
reg end_seen_r;
reg pushed_r;
reg [7:0] code1;
reg fifo_wr;
wire fifo_out_valid;
wire [7:0] fifo_out_data;
wire fifo_pop;
wire fifo_in_ready;
wire aligned;
wire protect_er;
wire protect_pg;
wire boot_hit;

// Byte FIFO between the data frame receiver and the flash writer
fepcs_fifo #(
	.WIDTH(8),
	.DEPTH(`FEPCS_FIFO_DEPTH),
	.AW(`FEPCS_FIFO_AW)
) u_fifo (
	.clock(clock),
	.nrst(nrst),
	.in_valid(fifo_wr),
	.in_ready(fifo_in_ready),
	.in_data(data_byte),
	.out_valid(fifo_out_valid),
	.out_ready(fifo_pop),
	.out_data(fifo_out_data)
);

// Bytes accepted only while receiving, stalled by FIFO back-pressure
assign data_ready = (state_r == S_RECV) & fifo_in_ready;
always @* begin
	fifo_wr = data_valid & data_ready;
end

// Flash writer pops one byte when the array is idle
assign fifo_pop = (state_r == S_RECV) & ~fl_write_r & ~fl_erase_r;

// Range checks on the raw command addresses
function blk_ok;
	input [AW-1:0] s;
	input [AW-1:0] e;
	begin
		blk_ok = (s[`FEPCS_BLK_BITS-1:0] == `FEPCS_BLK_LOW) &&
			(e[`FEPCS_BLK_BITS-1:0] == `FEPCS_BLK_HIGH) && (s <= e);
	end
endfunction

assign aligned = blk_ok(cmd_start_addr, cmd_end_addr);
assign boot_hit = sec_boot_dis & (cmd_start_addr <= boot_end_addr);
assign protect_er = sec_write_dis | sec_blk_erase_dis |
	sec_chip_erase_dis | boot_hit;
assign protect_pg = sec_write_dis | boot_hit;

// Command screening: first status byte for a new command
always @* begin
	code1 = `FEPCS_ST_ACK;
	if (!cmd_form_ok)
		code1 = `FEPCS_ST_NACK;
	else if (!cmd_csum_ok)
		code1 = `FEPCS_ST_CSUM;
	else if (!aligned)
		code1 = `FEPCS_ST_PARAM;
	else if (cmd_code == `FEPCS_CMD_ERASE && protect_er)
		code1 = `FEPCS_ST_PROTECT;
	else if (cmd_code == `FEPCS_CMD_PROG && protect_pg)
		code1 = `FEPCS_ST_PROTECT;
end

// Next state
always @* begin
	state_nxt = state_r;
	case (state_r)
	S_IDLE: begin
		if (cmd_valid && code1 == `FEPCS_ST_ACK) begin
			if (cmd_code == `FEPCS_CMD_ERASE)
				state_nxt = S_ERASE;
			else if (cmd_code == `FEPCS_CMD_PROG)
				state_nxt = S_RECV;
		end
	end
	S_ERASE: begin
		if (fl_done && (fl_fail || cur_r[AW-1:`FEPCS_BLK_BITS] ==
			end_r[AW-1:`FEPCS_BLK_BITS]))
			state_nxt = S_IDLE;
	end
	S_RECV: begin
		if (fifo_out_valid && fifo_pop)
			state_nxt = S_WRITE;
		else if (!pushed_r && !fifo_out_valid) begin
			if (end_seen_r && (frame_bad_r || wr_fail_r))
				state_nxt = S_DRAIN;
			else if (!end_seen_r && frame_last_r)
				state_nxt = S_VERIFY;
		end
	end
	S_WRITE: begin
		if (fl_done)
			state_nxt = S_RECV;
	end
	S_VERIFY: begin
		if (vcnt_r == 32'h0000_0000)
			state_nxt = S_IDLE;
	end
	S_DRAIN: begin
		if (!fifo_out_valid)
			state_nxt = S_IDLE;
	end
	default: state_nxt = S_IDLE;
	endcase
end

// Sequencer datapath and status reporting
always @(posedge clock or negedge nrst) begin
	if (!nrst) begin
		state_r <= S_IDLE;
		cur_r <= {AW{1'b0}};
		end_r <= {AW{1'b0}};
		blocks_r <= {(AW-`FEPCS_BLK_BITS+1){1'b0}};
		vcnt_r <= 32'h0000_0000;
		frame_bad_r <= 1'b0;
		frame_last_r <= 1'b0;
		wr_fail_r <= 1'b0;
		end_seen_r <= 1'b0;
		pushed_r <= 1'b0;
		fl_erase_r <= 1'b0;
		fl_write_r <= 1'b0;
		fl_addr_r <= {AW{1'b0}};
		fl_wdata_r <= 8'h00;
		stat_valid_r <= 1'b0;
		stat_two_r <= 1'b0;
		first_status_byte <= 8'h00;
		second_status_byte <= 8'h00;
		busy_r <= 1'b0;
	end else begin
		state_r <= state_nxt;
		stat_valid_r <= 1'b0;
		fl_erase_r <= 1'b0;
		fl_write_r <= 1'b0;
		busy_r <= (state_nxt != S_IDLE);
		pushed_r <= fifo_wr;
		// Busy: any command but status is refused
		if (cmd_valid && state_r != S_IDLE &&
			cmd_code != `FEPCS_CMD_STATUS) begin
			stat_valid_r <= 1'b1;
			stat_two_r <= 1'b0;
			first_status_byte <= `FEPCS_ST_NACK;
		end
		case (state_r)
		S_IDLE: begin
			if (cmd_valid && cmd_code != `FEPCS_CMD_STATUS) begin
				cur_r <= cmd_start_addr;
				end_r <= cmd_end_addr;
				blocks_r <= {1'b0, cmd_end_addr[AW-1:`FEPCS_BLK_BITS]} -
					{1'b0, cmd_start_addr[AW-1:`FEPCS_BLK_BITS]} +
					{{(AW-`FEPCS_BLK_BITS){1'b0}}, 1'b1};
				frame_bad_r <= 1'b0;
				frame_last_r <= 1'b0;
				wr_fail_r <= 1'b0;
				if (code1 == `FEPCS_ST_ACK &&
					cmd_code == `FEPCS_CMD_ERASE) begin
					fl_erase_r <= 1'b1;
					fl_addr_r <= cmd_start_addr;
				end else begin
					// Program ack, or any error, answered at once
					stat_valid_r <= 1'b1;
					stat_two_r <= 1'b0;
					first_status_byte <= code1;
				end
			end
		end
		S_ERASE: begin
			// Erase block by block until the end block or a failure
			if (fl_done) begin
				if (fl_fail) begin
					stat_valid_r <= 1'b1;
					stat_two_r <= 1'b0;
					first_status_byte <= `FEPCS_ST_FAIL;
					cur_r <= {AW{1'b0}};
				end else if (cur_r[AW-1:`FEPCS_BLK_BITS] ==
					end_r[AW-1:`FEPCS_BLK_BITS]) begin
					stat_valid_r <= 1'b1;
					stat_two_r <= 1'b0;
					first_status_byte <= `FEPCS_ST_ACK;
					cur_r <= {AW{1'b0}};
				end else begin
					cur_r <= {cur_r[AW-1:`FEPCS_BLK_BITS] + 1'b1,
						`FEPCS_BLK_LOW};
					fl_addr_r <= {cur_r[AW-1:`FEPCS_BLK_BITS] + 1'b1,
						`FEPCS_BLK_LOW};
					fl_erase_r <= 1'b1;
				end
			end
		end
		S_RECV: begin
			if (fifo_out_valid && fifo_pop) begin
				fl_write_r <= 1'b1;
				fl_addr_r <= cur_r;
				fl_wdata_r <= fifo_out_data;
			end
			// Latch the frame end; answer once its bytes are written
			if (fifo_wr && data_frame_end) begin
				end_seen_r <= 1'b1;
				frame_bad_r <= !data_csum_ok;
				frame_last_r <= data_frame_last;
			end
			if (end_seen_r && !pushed_r && !fifo_out_valid) begin
				end_seen_r <= 1'b0;
				stat_valid_r <= 1'b1;
				stat_two_r <= 1'b1;
				if (frame_bad_r) begin
					first_status_byte <= `FEPCS_ST_CSUM;
					second_status_byte <= `FEPCS_ST_CSUM;
				end else if (wr_fail_r) begin
					first_status_byte <= `FEPCS_ST_ACK;
					second_status_byte <= `FEPCS_ST_WRITE;
				end else begin
					first_status_byte <= `FEPCS_ST_ACK;
					second_status_byte <= `FEPCS_ST_ACK;
				end
			end
			if (state_nxt == S_VERIFY)
				vcnt_r <= VERIFY_CYC * blocks_r;
		end
		S_WRITE: begin
			if (fl_done) begin
				cur_r <= cur_r + 1'b1;
				if (fl_fail)
					wr_fail_r <= 1'b1;
			end
		end
		S_VERIFY: begin
			// Internal verify over programmed blocks, then final status
			if (vcnt_r != 32'h0000_0000) begin
				vcnt_r <= vcnt_r - 32'h0000_0001;
			end else begin
				stat_valid_r <= 1'b1;
				stat_two_r <= 1'b0;
				first_status_byte <= fl_verify_ok ? `FEPCS_ST_ACK :
					`FEPCS_ST_VERIFY;
			end
		end
		default: begin
			frame_last_r <= 1'b0;
		end
		endcase
	end
end

endmodule

// ### verification/fepcs_seq_props.sv
// Concurrent checks on the sequencer status answers
`timescale 1ns/100ps
module fepcs_seq_props #(
	parameter AW = 20
) (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Command and data inputs
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_code,
	input wire logic cmd_csum_ok,
	input wire logic cmd_form_ok,
	input wire logic [AW-1:0] cmd_start_addr,
	input wire logic [AW-1:0] cmd_end_addr,
	input wire logic data_valid,
	input wire logic data_ready,
	input wire logic data_frame_end,
	input wire logic data_csum_ok,
	input wire logic sec_write_dis,
	input wire logic sec_boot_dis,
	// Status outputs
	input wire logic stat_valid_r,
	input wire logic stat_two_r,
	input wire logic [7:0] first_status_byte,
	input wire logic [7:0] second_status_byte,
	input wire logic busy_r
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// Idle erase or program command and its checks
	wire take = cmd_valid && !busy_r && (cmd_code[0] != cmd_code[1]);
	wire good = take && cmd_form_ok && cmd_csum_ok;
	wire aok = cmd_start_addr[9:0] == 10'h000
		&& cmd_end_addr[9:0] == 10'h3ff && cmd_start_addr <= cmd_end_addr;
	wire prog = good && cmd_code == 2'h2 && aok;
	sequence stat1(logic [7:0] c);
		stat_valid_r && !stat_two_r && first_status_byte == c;
	endsequence
	sequence stat2(logic [7:0] c);
		stat_valid_r && stat_two_r && first_status_byte == c
			&& second_status_byte == c;
	endsequence
	form_nack_a: assert property (
		take && !cmd_form_ok |=> stat1(8'h15)) else $error("bad form");
	csum_err_a: assert property (
		take && cmd_form_ok && !cmd_csum_ok |=> stat1(8'h07))
		else $error("bad checksum");
	param_err_a: assert property (
		good && !aok |=> stat1(8'h05)) else $error("bad range");
	prog_ack_a: assert property (
		prog && !sec_write_dis && !sec_boot_dis |=> stat1(8'h06))
		else $error("no program ack");
	prog_protect_a: assert property (
		prog && sec_write_dis |=> stat1(8'h10)) else $error("no protect");
	busy_nack_a: assert property (
		cmd_valid && busy_r && cmd_code != 2'h0 |=> stat1(8'h15))
		else $error("busy command not refused");
	data_csum_a: assert property (
		data_valid && data_ready && data_frame_end && !data_csum_ok
		|-> ##[1:300] stat2(8'h07)) else $error("data checksum");
	stat_pulse_a: assert property (
		stat_valid_r |=> !stat_valid_r) else $error("status held");
endmodule
bind fepcs_seq fepcs_seq_props #(.AW(AW)) u_props (.clock(clock),
	.nrst(nrst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
	.cmd_csum_ok(cmd_csum_ok), .cmd_form_ok(cmd_form_ok),
	.cmd_start_addr(cmd_start_addr), .cmd_end_addr(cmd_end_addr),
	.data_valid(data_valid), .data_ready(data_ready),
	.data_frame_end(data_frame_end), .data_csum_ok(data_csum_ok),
	.sec_write_dis(sec_write_dis), .sec_boot_dis(sec_boot_dis),
	.stat_valid_r(stat_valid_r), .stat_two_r(stat_two_r),
	.first_status_byte(first_status_byte),
	.second_status_byte(second_status_byte), .busy_r(busy_r));

// ### verification/fepcs_flash_model.sv
// Behavioural flash array answering erase and write pulses
`timescale 1ns/100ps
module fepcs_flash_model (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Requests and test controls
	input wire logic fl_erase_r,
	input wire logic fl_write_r,
	input wire logic fail_en,
	input wire logic vgood,
	// Answers
	output logic fl_done,
	output logic fl_fail,
	output logic fl_verify_ok
);
	logic [2:0] wait_r;
	logic pend_r, tog_r;
	// Finish each operation 1 to 6 cycles after the request is sampled, by a random wait of 0 to 5
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			{pend_r, tog_r, fl_done, wait_r} <= 6'h00;
		end else begin
			tog_r <= !tog_r;
			fl_done <= pend_r && wait_r == 3'h0;
			if (fl_erase_r || fl_write_r) begin
				pend_r <= 1'b1;
				wait_r <= 3'($urandom_range(5, 0));
			end else if (pend_r && wait_r == 3'h0)
				pend_r <= 1'b0;
			else if (pend_r)
				wait_r <= wait_r - 3'h1;
		end
	end
	// Fail flag means nothing outside done, so it toggles there
	assign fl_fail = fl_done ? fail_en : tog_r;
	assign fl_verify_ok = vgood;
endmodule

// ### verification/fepcs_seq_test.sv
// Self-checking bench for the erase and program sequencer
`timescale 1ns/100ps
module fepcs_seq_test;
	logic clock = 0, nrst = 0, cmd_valid = 0, form = 1, csum = 1;
	logic [1:0] code = 0;
	logic [19:0] sa = 0, ea = 0, boot_end = 20'h003ff;
	logic dv = 0, dend = 0, dlast = 0, dok = 1, fail_en = 0, vgood = 1;
	logic [7:0] db = 0;
	logic [3:0] sec = 0;
	wire data_ready, fl_erase_r, fl_write_r, fl_done, fl_fail, fl_verify_ok;
	wire stat_valid_r, stat_two_r, busy_r;
	wire [7:0] st1, st2;
	wire [19:0] fl_addr;
	wire [7:0] fl_wdata;
	logic [19:0] wa = 20'h00400;
	logic [27:0] ew;
	logic [7:0] dq[$];
	logic [16:0] exp_q[$];
	logic [16:0] e, seen;
	int error_cnt = 0, comparisons = 0;

	always #25 clock = ~clock;

	fepcs_seq #(.VERIFY_CYC(2)) DUT (.clock(clock), .nrst(nrst),
		.cmd_valid(cmd_valid), .cmd_code(code), .cmd_csum_ok(csum),
		.cmd_form_ok(form), .cmd_start_addr(sa), .cmd_end_addr(ea),
		.data_valid(dv), .data_ready(data_ready), .data_byte(db),
		.data_frame_end(dend), .data_frame_last(dlast), .data_csum_ok(dok),
		.sec_write_dis(sec[0]), .sec_blk_erase_dis(sec[1]),
		.sec_chip_erase_dis(sec[2]), .sec_boot_dis(sec[3]),
		.boot_end_addr(boot_end), .fl_erase_r(fl_erase_r),
		.fl_write_r(fl_write_r), .fl_addr_r(fl_addr), .fl_wdata_r(fl_wdata),
		.fl_done(fl_done), .fl_fail(fl_fail), .fl_verify_ok(fl_verify_ok),
		.stat_valid_r(stat_valid_r), .stat_two_r(stat_two_r),
		.first_status_byte(st1), .second_status_byte(st2), .busy_r(busy_r));

	fepcs_flash_model u_flash (.clock(clock), .nrst(nrst),
		.fl_erase_r(fl_erase_r), .fl_write_r(fl_write_r),
		.fail_en(fail_en), .vgood(vgood), .fl_done(fl_done),
		.fl_fail(fl_fail), .fl_verify_ok(fl_verify_ok));

	// Compare each status frame with the oldest expected one
	always @(posedge clock) begin
		if (nrst && stat_valid_r === 1'b1) begin
			seen = {stat_two_r, st1, stat_two_r ? st2 : 8'h00};
			e = exp_q.size() ? exp_q.pop_front() : 17'h1ffff;
			comparisons++;
			if (seen !== e) begin
				error_cnt++;
				$display("mismatch status expected %h seen %h", e, seen);
			end
		end
	end

	// Each flash write takes the next address and the next sent byte;
	// every accepted program command here starts at 20'h00400
	always @(posedge clock) begin
		if (nrst && fl_write_r === 1'b1) begin
			ew = {wa, dq.size() ? dq.pop_front() : 8'h00};
			wa <= wa + 20'h00001;
			comparisons++;
			if ({fl_addr, fl_wdata} !== ew) begin
				error_cnt++;
				$display("mismatch flash_write expected %h seen %h", ew,
					{fl_addr, fl_wdata});
			end
		end else if (busy_r === 1'b0)
			wa <= 20'h00400;
	end

	function logic [16:0] one(logic [7:0] a);
		return {1'b0, a, 8'h00};
	endfunction
	function logic [16:0] two(logic [7:0] a, logic [7:0] b);
		return {1'b1, a, b};
	endfunction

	// Command frame after the command gap
	task cmd(logic [1:0] c, logic [19:0] s, logic [19:0] t, logic f,
		logic k, logic [16:0] ex);
		repeat (4) @(posedge clock);
		exp_q.push_back(ex);
		{cmd_valid, code, sa, ea, form, csum} <= {1'b1, c, s, t, f, k};
		@(posedge clock);
		cmd_valid <= 1'b0;
	endtask

	// Data frame of n random bytes after the data gap
	task frame(int n, logic lst, logic ok, logic [16:0] ex);
		logic [7:0] b;
		repeat (3) @(posedge clock);
		exp_q.push_back(ex);
		for (int i = 0; i < n; i++) begin
			{dv, dend, dlast, dok} <= {1'b1, i == n - 1, lst, ok};
			b = 8'($urandom);
			db <= b;
			dq.push_back(b);
			do @(posedge clock); while (data_ready !== 1'b1);
		end
		{dv, dend} <= 2'b00;
	endtask

	// Wait for every expected status under a time-out
	task sync;
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 4000) begin
			@(posedge clock);
			n++;
		end
		if (n >= 4000) begin
			error_cnt++;
			$display("mismatch status_wait expected 0 seen %0d", exp_q.size());
		end
	endtask

	task test_done;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	//--------------------------------------------------
	// Main sequence
	//--------------------------------------------------
	initial begin
		void'($urandom(32'h85b126a5));
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		cmd(1, 20'h00000, 20'h003ff, 0, 1, one(8'h15)); sync;
		cmd(2, 20'h00000, 20'h003ff, 1, 0, one(8'h07)); sync;
		cmd(1, 20'h00010, 20'h003ff, 1, 1, one(8'h05)); sync;
		cmd(2, 20'h00400, 20'h007fe, 1, 1, one(8'h05)); sync;
		for (int i = 0; i < 4; i++) begin
			sec <= 4'h1 << i;
			cmd(1, 20'h00000, 20'h007ff, 1, 1, one(8'h10)); sync;
		end
		sec <= 4'h1;
		cmd(2, 20'h00400, 20'h007ff, 1, 1, one(8'h10)); sync;
		sec <= 4'h0;
		cmd(1, 20'h00800, 20'h00fff, 1, 1, one(8'h06)); sync;
		fail_en <= 1'b1;
		cmd(1, 20'h00800, 20'h00bff, 1, 1, one(8'h1a)); sync;
		for (int r = 0; r < 4; r++) begin
			fail_en <= r == 1;
			vgood <= r != 2;
			cmd(2, 20'h00400, 20'h007ff, 1, 1, one(8'h06)); sync;
			if (r == 0) begin
				cmd(1, 20'h00000, 20'h003ff, 1, 1, one(8'h15)); sync;
				frame(4, 0, 1, two(8'h06, 8'h06)); sync;
			end
			frame(3, 1, r != 3, r == 1 ? two(8'h06, 8'h1c) :
				r == 3 ? two(8'h07, 8'h07) : two(8'h06, 8'h06));
			if (r == 0 || r == 2)
				exp_q.push_back(one(r == 2 ? 8'h1b : 8'h06));
			sync;
		end
		test_done;
	end

	// Watchdog against a hung handshake
	initial begin
		#(50 * 60000);
		error_cnt++;
		test_done;
	end
endmodule
